// ### pgca_consts.vh
`ifndef PGCA_CONSTS_VH
`define PGCA_CONSTS_VH
// ==================================================
// Register offsets (byte addresses)
`define PGCA_OFS_CNT_LO   8'h00
`define PGCA_OFS_CNT_HI   8'h04
`define PGCA_OFS_AMODE    8'h08
`define PGCA_OFS_ACTRL    8'h0c
`define PGCA_OFS_IRQCTL   8'h40
`define PGCA_MOD_SLOT0    4'h1
`define PGCA_MOD_MODE     4'h0
`define PGCA_MOD_LOW      4'h4
`define PGCA_MOD_HIGH     4'h8
// ==================================================
// Array mode register fields
`define PGCA_AM_OVF_IE    0
`define PGCA_AM_TB_LSB    1
`define PGCA_AM_TB_MSB    3
`define PGCA_AM_WDOG      6
`define PGCA_AM_IDLE      7
`define PGCA_AM_RESET     8'h40
// ==================================================
// Array control register fields
`define PGCA_AC_OVF       7
`define PGCA_AC_RUN       6
// ==================================================
// Interrupt control fields
`define PGCA_IC_GLOBAL    0
`define PGCA_IC_ARRAY     1
// ==================================================
// Module mode register fields
`define PGCA_MM_IE        0
`define PGCA_MM_PWM       1
`define PGCA_MM_TOG       2
`define PGCA_MM_MAT       3
`define PGCA_MM_FALL      4
`define PGCA_MM_RISE      5
`define PGCA_MM_ECOM      6
`define PGCA_MM_WIDE      7
// ==================================================
// Timebase selections
`define PGCA_TB_DIV12     3'h0
`define PGCA_TB_DIV4      3'h1
`define PGCA_TB_T0OVF     3'h2
`define PGCA_TB_EXTIN     3'h3
`define PGCA_TB_SYSCLK    3'h4
`define PGCA_TB_OSC8      3'h5
// ==================================================
// Divider limits, counter maxima and watchdog module
`define PGCA_DIV12_LAST   4'hb
`define PGCA_DIV4_LAST    2'h3
`define PGCA_OSC8_LAST    3'h7
`define PGCA_BYTE_MAX     8'hff
`define PGCA_WORD_MAX     16'hffff
`define PGCA_WDOG_MODULE  2
`endif

// ### pgca_top.v
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
`include "pgca_consts.vh"

module pgca_top #(
  parameter NMOD = 3
) (
  // APB
  input  wire             pclk,
  input  wire             presetn,
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [7:0]       paddr,
  input  wire [31:0]      pwdata,
  output reg  [31:0]      prdata,
  output wire             pready,
  output wire             pslverr,
  // Timebase sources
  input  wire             timer0_overflow,
  input  wire             external_count_input,
  input  wire             ext_osc_clk,
  input  wire             cpu_idle,
  // Module pins
  input  wire [NMOD-1:0]  module_pin_in,
  output wire [NMOD-1:0]  module_pin_out,
  output wire [NMOD-1:0]  module_pin_oe,
  // Interrupt
  output wire             irq
);

  localparam M_NONE  = 3'h0;
  localparam M_CAP   = 3'h1;
  localparam M_TIMER = 3'h2;
  localparam M_HSO   = 3'h3;
  localparam M_FREQ  = 3'h4;
  localparam M_PWM8  = 3'h5;
  localparam M_PWM16 = 3'h6;

  // ==================================================
  // Decode helpers
  function [2:0] mode_of;
    input [7:0] m;
    begin
      if (m[`PGCA_MM_ECOM] && m[`PGCA_MM_TOG] && m[`PGCA_MM_PWM])
        mode_of = M_FREQ;
      else if (m[`PGCA_MM_ECOM] && m[`PGCA_MM_PWM] && !m[`PGCA_MM_TOG])
        mode_of = m[`PGCA_MM_WIDE] ? M_PWM16 : M_PWM8;
      else if (m[`PGCA_MM_ECOM] && m[`PGCA_MM_MAT] && !m[`PGCA_MM_PWM])
        mode_of = m[`PGCA_MM_TOG] ? M_HSO : M_TIMER;
      else if ((m[`PGCA_MM_RISE] || m[`PGCA_MM_FALL]) && !m[`PGCA_MM_MAT]
               && !m[`PGCA_MM_TOG] && !m[`PGCA_MM_PWM])
        mode_of = M_CAP;
      else
        mode_of = M_NONE;
    end
  endfunction

  function mod_hit;
    input [7:0] a;
    input integer n;
    input [3:0] field;
    begin
      mod_hit = (a[7:4] == `PGCA_MOD_SLOT0 + n[3:0]) && (a[3:0] == field);
    end
  endfunction

  // ==================================================
  // Bus access
  wire wr_acc = psel && penable && pwrite;
  wire setup  = psel && !penable;

  reg  [15:0]     cnt_r;
  reg  [7:0]      snap_r;
  reg  [7:0]      amode_r;
  reg             ovf_flag_r;
  reg             run_r;
  reg  [1:0]      irqctl_r;
  wire [NMOD-1:0] ie_vec;
  wire [NMOD-1:0] mod_set;
  wire [NMOD*8-1:0] mode_bus;
  wire [NMOD*8-1:0] low_bus;
  wire [NMOD*8-1:0] high_bus;
  reg  [NMOD-1:0] flag_r;

  wire wdog = amode_r[`PGCA_AM_WDOG];

  reg [31:0] rd_mux;
  reg        hit;
  integer    k;
  always @*
  begin
    rd_mux = 32'h0000_0000;
    hit = 1'b1;
    case (paddr)
      `PGCA_OFS_CNT_LO: rd_mux[7:0] = cnt_r[7:0];
      `PGCA_OFS_CNT_HI: rd_mux[7:0] = snap_r;
      `PGCA_OFS_AMODE:  rd_mux[7:0] = amode_r;
      `PGCA_OFS_ACTRL:  rd_mux[7:0] = {ovf_flag_r, run_r, 3'h0, flag_r};
      `PGCA_OFS_IRQCTL: rd_mux[1:0] = irqctl_r;
      default:          hit = 1'b0;
    endcase
    for (k = 0; k < NMOD; k = k + 1)
    begin
      if (mod_hit(paddr, k, `PGCA_MOD_MODE))
      begin
        rd_mux[7:0] = mode_bus[k*8 +: 8];
        hit = 1'b1;
      end
      if (mod_hit(paddr, k, `PGCA_MOD_LOW))
      begin
        rd_mux[7:0] = low_bus[k*8 +: 8];
        hit = 1'b1;
      end
      if (mod_hit(paddr, k, `PGCA_MOD_HIGH))
      begin
        rd_mux[7:0] = high_bus[k*8 +: 8];
        hit = 1'b1;
      end
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  // Data is captured in setup so it comes from a flop yet still answers with no wait
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata <= rd_mux;
  end

  // ==================================================
  // Timebase generation
  reg [3:0] div12_r;
  reg [1:0] div4_r;
  reg [2:0] osc_cnt_r;
  reg       eci_s1_r, eci_s2_r, eci_d_r;
  reg       osc_s1_r, osc_s2_r, osc_d_r;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div12_r   <= 4'h0;
      div4_r    <= 2'h0;
      osc_cnt_r <= 3'h0;
      eci_s1_r  <= 1'b1;
      eci_s2_r  <= 1'b1;
      eci_d_r   <= 1'b1;
      osc_s1_r  <= 1'b0;
      osc_s2_r  <= 1'b0;
      osc_d_r   <= 1'b0;
    end
    else
    begin
      div12_r  <= (div12_r == `PGCA_DIV12_LAST) ? 4'h0 : div12_r + 4'h1;
      div4_r   <= div4_r + 2'h1;
      eci_s1_r <= external_count_input;
      eci_s2_r <= eci_s1_r;
      eci_d_r  <= eci_s2_r;
      osc_s1_r <= ext_osc_clk;
      osc_s2_r <= osc_s1_r;
      osc_d_r  <= osc_s2_r;
      if (osc_s2_r && !osc_d_r)
        osc_cnt_r <= osc_cnt_r + 3'h1;
    end
  end

  wire osc_rise = osc_s2_r && !osc_d_r;
  reg  tick;
  always @*
  begin
    case (amode_r[`PGCA_AM_TB_MSB:`PGCA_AM_TB_LSB])
      `PGCA_TB_DIV12:  tick = (div12_r == `PGCA_DIV12_LAST);
      `PGCA_TB_DIV4:   tick = (div4_r == `PGCA_DIV4_LAST);
      `PGCA_TB_T0OVF:  tick = timer0_overflow;
      `PGCA_TB_EXTIN:  tick = eci_d_r && !eci_s2_r;
      `PGCA_TB_SYSCLK: tick = 1'b1;
      `PGCA_TB_OSC8:   tick = osc_rise && (osc_cnt_r == `PGCA_OSC8_LAST);
      default:         tick = 1'b0;
    endcase
  end

  // Watchdog forces the counter on; idle only stops it when suspend is set
  wire running  = run_r || wdog;
  wire suspend  = cpu_idle && amode_r[`PGCA_AM_IDLE];
  wire cnt_en   = tick && running && !suspend;
  wire lo_wrap  = cnt_en && (cnt_r[7:0] == `PGCA_BYTE_MAX);
  wire wrap     = cnt_en && (cnt_r == `PGCA_WORD_MAX);

  // ==================================================
  // Counter, array registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r      <= 16'h0000;
      snap_r     <= 8'h00;
      amode_r    <= `PGCA_AM_RESET;
      ovf_flag_r <= 1'b0;
      run_r      <= 1'b0;
      irqctl_r   <= 2'h0;
      flag_r     <= {NMOD{1'b0}};
    end
    else
    begin
      if (wr_acc && !wdog && paddr == `PGCA_OFS_CNT_LO)
        cnt_r[7:0] <= pwdata[7:0];
      else if (wr_acc && !wdog && paddr == `PGCA_OFS_CNT_HI)
        cnt_r[15:8] <= pwdata[7:0];
      else if (cnt_en)
        cnt_r <= cnt_r + 16'h0001;
      // Taken at the same edge as the low byte, so both halves belong to one count
      if (setup && !pwrite && paddr == `PGCA_OFS_CNT_LO)
        snap_r <= cnt_r[15:8];
      if (wr_acc && paddr == `PGCA_OFS_AMODE)
      begin
        amode_r[`PGCA_AM_OVF_IE] <= pwdata[`PGCA_AM_OVF_IE];
        amode_r[`PGCA_AM_WDOG]   <= pwdata[`PGCA_AM_WDOG];
        if (!wdog)
        begin
          amode_r[`PGCA_AM_TB_MSB:`PGCA_AM_TB_LSB] <= pwdata[`PGCA_AM_TB_MSB:`PGCA_AM_TB_LSB];
          amode_r[`PGCA_AM_IDLE] <= pwdata[`PGCA_AM_IDLE];
        end
      end
      if (wr_acc && paddr == `PGCA_OFS_IRQCTL)
        irqctl_r <= pwdata[1:0];
      if (wr_acc && paddr == `PGCA_OFS_ACTRL)
        run_r <= pwdata[`PGCA_AC_RUN];
      // Writing zero clears a flag; a hardware set in the same cycle wins
      if (wrap)
        ovf_flag_r <= 1'b1;
      else if (wr_acc && paddr == `PGCA_OFS_ACTRL && !pwdata[`PGCA_AC_OVF])
        ovf_flag_r <= 1'b0;
      if (wr_acc && paddr == `PGCA_OFS_ACTRL)
        flag_r <= (flag_r & pwdata[NMOD-1:0]) | mod_set;
      else
        flag_r <= flag_r | mod_set;
    end
  end

  // ==================================================
  // Capture/compare modules
  genvar n;
  generate
    for (n = 0; n < NMOD; n = n + 1)
    begin : g_mod
      reg  [7:0] mode_r;
      reg  [7:0] low_r;
      reg  [7:0] high_r;
      reg        pin_r;
      reg        hso_d_r;
      reg        s1_r, s2_r, d_r;
      reg        set_r;
      wire [2:0] md = (wdog && n == `PGCA_WDOG_MODULE) ? M_TIMER : mode_of(mode_r);
      wire       rise = s2_r && !d_r;
      wire       fall = !s2_r && d_r;
      wire       edge_ok = (mode_r[`PGCA_MM_RISE] && rise) || (mode_r[`PGCA_MM_FALL] && fall);
      wire       m16 = cnt_en && (cnt_r == {high_r, low_r});
      wire       m8  = cnt_en && (cnt_r[7:0] == low_r);
      wire       w_mode = wr_acc && mod_hit(paddr, n, `PGCA_MOD_MODE)
                          && !(wdog && n == `PGCA_WDOG_MODULE);
      wire       w_low  = wr_acc && mod_hit(paddr, n, `PGCA_MOD_LOW);
      wire       w_high = wr_acc && mod_hit(paddr, n, `PGCA_MOD_HIGH);

      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          mode_r  <= 8'h00;
          low_r   <= 8'h00;
          high_r  <= 8'h00;
          pin_r   <= 1'b0;
          hso_d_r <= 1'b0;
          s1_r    <= 1'b0;
          s2_r    <= 1'b0;
          d_r     <= 1'b0;
          set_r   <= 1'b0;
        end
        else
        begin
          s1_r    <= module_pin_in[n];
          s2_r    <= s1_r;
          d_r     <= s2_r;
          hso_d_r <= (md == M_HSO);
          set_r   <= 1'b0;
          // Mode register, with the comparator enable side effects of byte writes
          if (w_mode)
            mode_r <= pwdata[7:0];
          else if (w_low)
            mode_r[`PGCA_MM_ECOM] <= 1'b0;
          else if (w_high)
            mode_r[`PGCA_MM_ECOM] <= 1'b1;
          if (w_low)
            low_r <= pwdata[7:0];
          if (w_high)
            high_r <= pwdata[7:0];
          case (md)
            M_CAP:
              if (edge_ok)
              begin
                low_r  <= cnt_r[7:0];
                high_r <= cnt_r[15:8];
                set_r  <= 1'b1;
              end
            M_TIMER:
              if (m16)
                set_r <= 1'b1;
            M_HSO:
              if (!hso_d_r)
                pin_r <= 1'b1;
              else if (m16)
              begin
                pin_r <= !pin_r;
                set_r <= 1'b1;
              end
            M_FREQ:
              if (m8)
              begin
                pin_r <= !pin_r;
                // A zero high byte adds nothing, so the next match is 256 counts later
                low_r <= low_r + high_r;
                set_r <= 1'b1;
              end
            M_PWM8:
              if (lo_wrap)
              begin
                pin_r <= 1'b0;
                low_r <= high_r;
              end
              else if (m8)
              begin
                pin_r <= 1'b1;
                set_r <= 1'b1;
              end
            M_PWM16:
              if (wrap)
                pin_r <= 1'b0;
              else if (m16)
              begin
                pin_r <= 1'b1;
                set_r <= 1'b1;
              end
            default:
              pin_r <= pin_r;
          endcase
        end
      end

      // Match flags only raise in modes that enable match, as capture does for edges
      assign mod_set[n] = set_r && (md == M_CAP || mode_r[`PGCA_MM_MAT] || md == M_TIMER);
      assign mode_bus[n*8 +: 8] = mode_r;
      assign ie_vec[n]          = mode_r[`PGCA_MM_IE];
      assign low_bus[n*8 +: 8]  = low_r;
      assign high_bus[n*8 +: 8] = high_r;
      assign module_pin_out[n]  = pin_r;
      assign module_pin_oe[n]   = (md == M_HSO) || (md == M_FREQ) || (md == M_PWM8) || (md == M_PWM16);
    end
  endgenerate

  // ==================================================
  // Interrupt request
  assign irq = irqctl_r[`PGCA_IC_GLOBAL] && irqctl_r[`PGCA_IC_ARRAY]
               && ((ovf_flag_r && amode_r[`PGCA_AM_OVF_IE]) || |(flag_r & ie_vec));

endmodule

// ### pgca_chk_assertions.sv
`timescale 1ns/10ps
// ==================================================
// Port-level checks for the counter array
module pgca_chk #(
  parameter NMOD = 3
) (
  // Bus
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [7:0]      paddr,
  input wire logic [31:0]     pwdata,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  // Pins and interrupt
  input wire logic [NMOD-1:0] module_pin_out,
  input wire logic [NMOD-1:0] module_pin_oe,
  input wire logic            irq
);
  // ==================================================
  // Helpers
  wire acc = psel && penable;
  wire wr0 = acc && pwrite && paddr == 8'h10 && pwdata[5:4] == 2'h0;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ==================================================
  // Assertions
  AST_ZERO_WAIT: assert property (acc |-> pready)
    else $error("pready low in access phase");
  AST_RD_HOLD: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved without a read");
  AST_RD_UPPER: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  AST_CNT_MAPPED: assert property (acc && (paddr == 8'h00 || paddr == 8'h04) |-> !pslverr)
    else $error("counter byte access refused");
  AST_IRQ_SW_CLEAR: assert property ($fell(irq) |-> $past(acc && pwrite))
    else $error("interrupt dropped without a write");
  AST_OE_ON_WRITE: assert property ($changed(module_pin_oe) |-> $past(acc && pwrite))
    else $error("pin enable moved without a write");
  AST_OE_DECODE: assert property (wr0 |=>
    module_pin_oe[0] == $past(pwdata[6] & (pwdata[1] | pwdata[3] & pwdata[2])))
    else $error("mode decode gives wrong pin enable");
  AST_HSO_ENTRY: assert property (wr0 && pwdata[7:0] == 8'h4c && !module_pin_oe[0]
    |-> ##[1:2] module_pin_out[0])
    else $error("toggle output not forced high");

  // ==================================================
  // Coverage
  COV_IRQ: cover property ($rose(irq));
  COV_TOGGLE: cover property ($fell(module_pin_out[0]));
  COV_ERR: cover property (acc && pslverr);
endmodule

bind pgca_top pgca_chk #(.NMOD(NMOD)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .module_pin_out(module_pin_out),
  .module_pin_oe(module_pin_oe), .irq(irq));

// ### pgca_src_model.sv
`timescale 1ns/10ps
// ==================================================
// Outside sources: count input and module pins
module pgca_src_model (
  // Clock
  input  wire logic       pclk,
  // Requested pin levels
  input  wire logic [2:0] pin_req,
  // Driven lines
  output logic            ext_count,
  output logic [2:0]      pins
);
  logic [1:0] div_r;

  initial
  begin
    div_r     = 2'h0;
    ext_count = 1'b1;
    pins      = 3'h0;
  end

  // Half period of four clocks keeps the rate at a quarter or less
  always @(posedge pclk)
  begin
    div_r <= div_r + 2'h1;
    if (div_r == 2'h3)
      ext_count <= ~ext_count;
    pins <= pin_req;
  end
endmodule

// ### tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb;
  // ==================================================
  // Signals
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        t0_ovf = 1'b0, osc = 1'b0, cpu_idle = 1'b1, pready, pslverr, irq, ext_cnt, last_err;
  logic [7:0]  paddr = 8'h00, rd_v, h;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [2:0]  pin_req = 3'h0, pins, pin_out, pin_oe, t0_div = 3'h0;
  logic [15:0] cnt, v;
  integer      err_total = 0, tests_run = 0, seed = 51995, i, j, k, hi;
  logic [7:0]  tb_mode [0:7] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0a, 8'h88, 8'h88};
  integer      tb_exp [0:7] = '{8, 24, 12, 12, 98, 4, 0, 98};
  logic [7:0]  cap_mode [0:2] = '{8'h20, 8'h10, 8'h30};

  pgca_top #(.NMOD(3)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer0_overflow(t0_ovf), .external_count_input(ext_cnt), .ext_osc_clk(osc),
    .cpu_idle(cpu_idle), .module_pin_in(pins), .module_pin_out(pin_out),
    .module_pin_oe(pin_oe), .irq(irq));
  pgca_src_model u_src (.pclk(pclk), .pin_req(pin_req), .ext_count(ext_cnt), .pins(pins));

  always #4 pclk = ~pclk;
  // Oscillator runs at a third of the bus clock rate, its edges falling on bus clock edges
  always #12 osc = ~osc;
  always @(posedge pclk)
  begin
    t0_div <= t0_div + 3'h1;
    t0_ovf <= (t0_div == 3'h0);
  end

  // ==================================================
  // Tasks
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd_v     = prdata[7:0];
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic set_cnt(input logic [15:0] c);
    apb(1'b1, 8'h0c, 8'h00);
    apb(1'b1, 8'h00, c[7:0]);
    apb(1'b1, 8'h04, c[15:8]);
  endtask

  task automatic rd_cnt();
    apb(1'b0, 8'h00, 8'h00);
    cnt[7:0] = rd_v;
    apb(1'b0, 8'h04, 8'h00);
    cnt[15:8] = rd_v;
  endtask

  task automatic meas(input integer n, input integer b, output integer tg, output integer hc);
    logic p;
    p  = pin_out[b];
    tg = 0;
    hc = 0;
    repeat (n)
    begin
      @(posedge pclk);
      tg = tg + (pin_out[b] !== p);
      hc = hc + (pin_out[b] === 1'b1);
      p  = pin_out[b];
    end
  endtask

  function automatic logic near(input logic [15:0] g, input integer e);
    near = (g + 3 >= e) && (g <= e + 3);
  endfunction

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #(60000 * 8);
    err_total++;
    end_sim();
  end

  // ==================================================
  // Sequence
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h08, 8'h00);
    `CHK(rd_v, 8'h40)
    apb(1'b1, 8'h08, 8'h4a);
    apb(1'b0, 8'h08, 8'h00);
    `CHK(rd_v, 8'h40)
    apb(1'b1, 8'h30, 8'h42);
    apb(1'b1, 8'h08, 8'h00);
    // Let the watchdog release settle before the pin enable is looked at
    @(posedge pclk);
    `CHK(pin_oe[2], 1'b0)
    apb(1'b0, 8'h1c, 8'h00);
    `CHK({last_err, rd_v}, 9'h100)
    // Timebases; the idle input drops for the last pass so suspend must not stop it
    for (i = 0; i < 8; i++)
    begin
      cpu_idle <= (i < 7);
      set_cnt(16'h0000);
      apb(1'b1, 8'h08, tb_mode[i]);
      apb(1'b1, 8'h0c, 8'h40);
      repeat (96) @(posedge pclk);
      apb(1'b1, 8'h0c, 8'h00);
      rd_cnt();
      `CHK(near(cnt, tb_exp[i]), 1'b1)
    end
    apb(1'b1, 8'h08, 8'h08);
    set_cnt(16'h1234);
    apb(1'b0, 8'h00, 8'h00);
    `CHK(rd_v, 8'h34)
    apb(1'b1, 8'h04, 8'h56);
    apb(1'b0, 8'h04, 8'h00);
    `CHK(rd_v, 8'h12)
    rd_cnt();
    `CHK(cnt, 16'h5634)
    // Overflow flag and interrupt gating
    set_cnt(16'hfff0);
    apb(1'b1, 8'h08, 8'h09);
    apb(1'b1, 8'h40, 8'h02);
    apb(1'b1, 8'h0c, 8'h40);
    repeat (30) @(posedge pclk);
    `CHK(irq, 1'b0)
    apb(1'b1, 8'h40, 8'h03);
    apb(1'b0, 8'h0c, 8'h00);
    `CHK({irq, rd_v[7]}, 2'b11)
    apb(1'b1, 8'h0c, 8'h40);
    apb(1'b1, 8'h08, 8'h08);
    `CHK(irq, 1'b0)
    // Software timer on module 0
    set_cnt(16'h0000);
    v = 16'h0040 | (16'($random(seed)) & 16'h007f);
    apb(1'b1, 8'h10, 8'h49);
    apb(1'b1, 8'h14, v[7:0]);
    apb(1'b0, 8'h10, 8'h00);
    `CHK(rd_v[6], 1'b0)
    apb(1'b1, 8'h18, v[15:8]);
    apb(1'b0, 8'h10, 8'h00);
    `CHK(rd_v, 8'h49)
    apb(1'b1, 8'h0c, 8'h40);
    repeat (v - 12) @(posedge pclk);
    `CHK(irq, 1'b0)
    repeat (20) @(posedge pclk);
    `CHK(irq, 1'b1)
    repeat (200) @(posedge pclk);
    apb(1'b0, 8'h0c, 8'h00);
    `CHK(rd_v[0], 1'b1)
    // High-speed output on module 0
    set_cnt(16'h0000);
    apb(1'b1, 8'h14, 8'h40);
    apb(1'b1, 8'h18, 8'h00);
    apb(1'b1, 8'h10, 8'h4c);
    apb(1'b1, 8'h0c, 8'h40);
    `CHK(pin_out[0], 1'b1)
    repeat (80) @(posedge pclk);
    `CHK(pin_out[0], 1'b0)
    // Frequency output on module 1
    set_cnt(16'h0000);
    h = 8'h02 + {5'h0, 3'($random(seed))};
    apb(1'b1, 8'h24, 8'h00);
    apb(1'b1, 8'h28, h);
    apb(1'b1, 8'h20, 8'h46);
    apb(1'b1, 8'h0c, 8'h40);
    meas(128, 1, k, hi);
    `CHK(near(16'(k), 128 / h), 1'b1)
    apb(1'b1, 8'h28, 8'h00);
    meas(600, 1, k, hi);
    `CHK(near(16'(k), 2), 1'b1)
    // Eight-bit pwm on module 0
    set_cnt(16'h0000);
    h = 8'h40 + {1'b0, 7'($random(seed))};
    apb(1'b1, 8'h14, 8'h00);
    apb(1'b1, 8'h18, h);
    apb(1'b1, 8'h10, 8'h42);
    apb(1'b1, 8'h0c, 8'h40);
    repeat (256) @(posedge pclk);
    meas(512, 0, k, hi);
    `CHK(near(16'(hi), 2 * (256 - h)), 1'b1)
    // Sixteen-bit pwm on module 0
    set_cnt(16'hff00);
    apb(1'b1, 8'h14, 8'h80);
    apb(1'b1, 8'h18, 8'hff);
    apb(1'b1, 8'h10, 8'hc2);
    apb(1'b1, 8'h0c, 8'h40);
    repeat (160) @(posedge pclk);
    `CHK(pin_out[0], 1'b1)
    repeat (128) @(posedge pclk);
    `CHK(pin_out[0], 1'b0)
    // Capture on module 2, every edge selection against both edges
    for (i = 0; i < 3; i++)
      for (j = 1; j >= 0; j--)
      begin
        v = 16'($random(seed));
        set_cnt(v);
        apb(1'b1, 8'h34, 8'h00);
        apb(1'b1, 8'h38, 8'h00);
        apb(1'b1, 8'h30, cap_mode[i]);
        pin_req[2] <= j[0];
        repeat (10) @(posedge pclk);
        k = j ? cap_mode[i][5] : cap_mode[i][4];
        apb(1'b0, 8'h0c, 8'h00);
        `CHK(rd_v[2], k[0])
        apb(1'b0, 8'h34, 8'h00);
        `CHK(rd_v, k ? v[7:0] : 8'h00)
      end
    end_sim();
  end
endmodule
